// [logic/gac_pkg.sv]
// Constants, register map and carrier types of the converter sequencer
package gac_pkg;

   // Register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_CTRL2  = 8'h04;
   localparam logic [7:0] OFF_TRIM_P = 8'h08;
   localparam logic [7:0] OFF_TRIM_N = 8'h0C;
   localparam logic [7:0] OFF_RESULT = 8'h10;

   // Field positions of converter_control_word
   localparam int CTL_EN_POS     = 0;
   localparam int CTL_START_POS  = 1;
   localparam int CTL_CHOP_POS   = 2;
   localparam int CTL_SE_POS     = 3;
   localparam int CTL_MUTE_POS   = 4;
   localparam int CTL_INV_POS    = 5;
   localparam int CTL_CH_POS     = 6;
   localparam int CTL_REG_POS    = 9;
   localparam int CTL_READY_POS  = 10;
   localparam int CTL_BUSY_POS   = 11;

   // Field positions of converter_control_word_two
   localparam int CT2_ATTN_POS   = 0;
   localparam int CT2_CLOAD_POS  = 1;
   localparam int CT2_DLOAD_POS  = 2;

   // Widths and reset values
   localparam int CODE_W = 10;
   localparam int CH_W   = 3;
   localparam logic [9:0] TRIM_RST   = 10'h200;
   localparam logic [9:0] RESULT_RST = 10'h000;
   localparam logic [2:0] CH_RST     = 3'h0;
   localparam logic [2:0] CH_BATTERY = 3'h4;

   // Timing
   localparam int CLK_PERIOD_PS  = 5000;
   localparam int REG_SETTLE_US  = 20;
   localparam int CONV_TIME_PS   = 62500;
   localparam int SETTLE_CYCLES  =
      (REG_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CONV_CYCLES    =
      (CONV_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [11:0] SETTLE_LAST = 12'(SETTLE_CYCLES - 1);
   localparam logic [3:0]  CONV_LAST   = 4'(CONV_CYCLES - 1);

   typedef enum logic [1:0]
   {
      S_OFF     = 2'b00,
      S_TRACK   = 2'b01,
      S_CONV    = 2'b11,
      S_RETRACK = 2'b10
   } gac_state_e;

   typedef struct packed
   {
      logic       reg_en;
      logic       inv;
      logic       mute;
      logic       se;
      logic       chop;
      logic [2:0] ch;
      logic       start;
      logic       conv_en;
   } gac_ctrl_s;

   typedef struct packed
   {
      logic dload;
      logic cload;
      logic attn;
   } gac_ctrl2_s;

   // Control lines toward the analogue converter
   typedef struct packed
   {
      logic       regulator_on;
      logic       track;
      logic       hold;
      logic [2:0] mux_sel;
      logic       differential;
      logic       atten;
      logic       load20;
      logic       load10;
      logic       mute;
      logic       invert;
      logic [9:0] trim_pos;
      logic [9:0] trim_neg;
      logic [3:0] pin_connect;
   } gac_analog_s;

endpackage

// [logic/gac_sequencer.sv]
// Control sequencer and register file of the general purpose converter
`timescale 1ns/1ps

module gac_sequencer
(
   input  wire logic                          core_clk,
   input  wire logic                          reset,
   input  wire logic [gac_pkg::ADDR_W-1:0]    addr,
   input  wire logic [gac_pkg::DATA_W-1:0]    wr_data,
   input  wire logic                          wr_en,
   input  wire logic                          rd_en,
   output logic      [gac_pkg::DATA_W-1:0]    rd_data,
   input  wire logic [gac_pkg::CODE_W-1:0]    raw_code,
   input  wire logic [3:0]                    analog_sel,
   output gac_pkg::gac_analog_s               ana
);
   import gac_pkg::*;

   typedef struct packed
   {
      gac_state_e       fsm;
      gac_ctrl_s        ctl;
      gac_ctrl2_s       ctl2;
      logic [9:0]       trim_p;
      logic [9:0]       trim_n;
      logic [9:0]       result;
      logic [11:0]      settle_cnt;
      logic             reg_ready;
      logic [3:0]       conv_cnt;
      logic             chop_phase;
      logic [9:0]       first_code;
      logic [9:0]       sync1;
      logic [9:0]       sync2;
      logic [31:0]      rdata;
      gac_analog_s      ana;
   } gac_regs_s;

   gac_regs_s st;
   gac_regs_s next_st;

   logic        wr_ctrl;
   logic        start_set;
   logic        active;
   logic        conv_end;
   logic        done;
   logic [9:0]  code_fix;
   logic [10:0] chop_sum;

   assign rd_data = st.rdata;
   assign ana     = st.ana;

   always_comb
   begin
      next_st = st;
      wr_ctrl   = wr_en && (addr == OFF_CTRL);
      start_set = wr_ctrl && wr_data[CTL_START_POS];
      done      = 1'b0;

      // Sampled converter code crosses in from the analogue side
      next_st.sync1 = raw_code;
      next_st.sync2 = st.sync1;

      // Register writes
      if (wr_ctrl)
      begin
         next_st.ctl.conv_en = wr_data[CTL_EN_POS];
         next_st.ctl.chop    = wr_data[CTL_CHOP_POS];
         next_st.ctl.se      = wr_data[CTL_SE_POS];
         next_st.ctl.mute    = wr_data[CTL_MUTE_POS];
         next_st.ctl.inv     = wr_data[CTL_INV_POS];
         next_st.ctl.ch      = wr_data[CTL_CH_POS +: CH_W];
         next_st.ctl.reg_en  = wr_data[CTL_REG_POS];
      end
      if (wr_en && (addr == OFF_CTRL2))
      begin
         next_st.ctl2.attn  = wr_data[CT2_ATTN_POS];
         next_st.ctl2.cload = wr_data[CT2_CLOAD_POS];
         next_st.ctl2.dload = wr_data[CT2_DLOAD_POS];
      end
      if (wr_en && (addr == OFF_TRIM_P))
      begin
         next_st.trim_p = wr_data[CODE_W-1:0];
      end
      if (wr_en && (addr == OFF_TRIM_N))
      begin
         next_st.trim_n = wr_data[CODE_W-1:0];
      end

      // Regulator settling status, restarts whenever it is switched off
      if (!next_st.ctl.reg_en)
      begin
         next_st.settle_cnt = '0;
         next_st.reg_ready  = 1'b0;
      end
      else if (st.settle_cnt != SETTLE_LAST)
      begin
         next_st.settle_cnt = st.settle_cnt + 12'h001;
      end
      else
      begin
         next_st.reg_ready = 1'b1;
      end

      // Regulator off takes the whole converter down
      active = next_st.ctl.reg_en && next_st.ctl.conv_en;

      // Output sign change is a code inversion about 511.5
      code_fix = st.ctl.inv ^ st.chop_phase ? ~st.sync2 : st.sync2;
      chop_sum = {1'b0, st.first_code} + {1'b0, code_fix};
      conv_end = (st.conv_cnt == CONV_LAST);

      case (st.fsm)
         S_OFF:
         begin
            if (active)
            begin
               next_st.fsm = S_TRACK;
            end
         end
         S_TRACK:
         begin
            if (!active)
            begin
               next_st.fsm = S_OFF;
            end
            else if (st.ctl.start)
            begin
               next_st.fsm        = S_CONV;
               next_st.conv_cnt   = '0;
               next_st.chop_phase = 1'b0;
            end
         end
         S_CONV:
         begin
            next_st.conv_cnt = st.conv_cnt + 4'h1;
            if (!active)
            begin
               next_st.fsm = S_OFF;
               done        = 1'b1;
            end
            else if (conv_end && st.ctl.chop && !st.chop_phase)
            begin
               // First half of a chopped pair, resample with sign flipped
               next_st.first_code = code_fix;
               next_st.chop_phase = 1'b1;
               next_st.conv_cnt   = '0;
               next_st.fsm        = S_RETRACK;
            end
            else if (conv_end)
            begin
               next_st.result = st.chop_phase ? chop_sum[10:1] : code_fix;
               next_st.fsm    = S_TRACK;
               done           = 1'b1;
            end
         end
         S_RETRACK:
         begin
            next_st.conv_cnt = st.conv_cnt + 4'h1;
            if (!active)
            begin
               next_st.fsm = S_OFF;
               done        = 1'b1;
            end
            else if (conv_end)
            begin
               next_st.conv_cnt = '0;
               next_st.fsm      = S_CONV;
            end
         end
         default:
         begin
            next_st.fsm = S_OFF;
         end
      endcase

      next_st.chop_phase = next_st.chop_phase &&
                           ((next_st.fsm == S_CONV) || (next_st.fsm == S_RETRACK));
      // A new start written in the completing cycle is kept
      next_st.ctl.start = (st.ctl.start && !done) || start_set;

      // Control lines to the analogue converter
      next_st.ana.regulator_on = next_st.ctl.reg_en;
      next_st.ana.track        = (next_st.fsm == S_TRACK) ||
                                 (next_st.fsm == S_RETRACK);
      next_st.ana.hold         = (next_st.fsm == S_CONV);
      next_st.ana.mux_sel      = next_st.ctl.ch;
      next_st.ana.differential = !next_st.ctl.se;
      // Battery channel forces the attenuator in
      next_st.ana.atten        = next_st.ctl2.attn ||
                                 (next_st.ctl.ch == CH_BATTERY);
      next_st.ana.load20       = next_st.ctl2.cload &&
                                 next_st.ctl.reg_en;
      next_st.ana.load10       = next_st.ctl2.dload &&
                                 next_st.ana.track;
      next_st.ana.mute         = next_st.ctl.mute;
      next_st.ana.invert       = next_st.ctl.inv ^ next_st.chop_phase;
      next_st.ana.trim_pos     = next_st.trim_p;
      next_st.ana.trim_neg     = next_st.trim_n;

      // Pins feed the mux only when their analogue function is chosen
      next_st.ana.pin_connect = '0;
      if (next_st.ctl.ch[2] == 1'b0)
      begin
         if (next_st.ctl.se)
         begin
            next_st.ana.pin_connect[next_st.ctl.ch[1:0]] = 1'b1;
         end
         else
         begin
            // Pairs are pins 0/1 and 2/3
            next_st.ana.pin_connect[{next_st.ctl.ch[0], 1'b0}] = 1'b1;
            next_st.ana.pin_connect[{next_st.ctl.ch[0], 1'b1}] = 1'b1;
         end
      end
      next_st.ana.pin_connect = next_st.ana.pin_connect & analog_sel;

      // Register reads, data stand one cycle after the strobe
      next_st.rdata = '0;
      if (rd_en)
      begin
         case (addr)
            OFF_CTRL:
            begin
               next_st.rdata[CTL_EN_POS]         = st.ctl.conv_en;
               next_st.rdata[CTL_START_POS]      = st.ctl.start;
               next_st.rdata[CTL_CHOP_POS]       = st.ctl.chop;
               next_st.rdata[CTL_SE_POS]         = st.ctl.se;
               next_st.rdata[CTL_MUTE_POS]       = st.ctl.mute;
               next_st.rdata[CTL_INV_POS]        = st.ctl.inv;
               next_st.rdata[CTL_CH_POS +: CH_W] = st.ctl.ch;
               next_st.rdata[CTL_REG_POS]        = st.ctl.reg_en;
               next_st.rdata[CTL_READY_POS]      = st.reg_ready;
               next_st.rdata[CTL_BUSY_POS]       = (st.fsm == S_CONV) ||
                                                   (st.fsm == S_RETRACK);
            end
            OFF_CTRL2:
            begin
               next_st.rdata[CT2_ATTN_POS]  = st.ctl2.attn;
               next_st.rdata[CT2_CLOAD_POS] = st.ctl2.cload;
               next_st.rdata[CT2_DLOAD_POS] = st.ctl2.dload;
            end
            OFF_TRIM_P:
            begin
               next_st.rdata[CODE_W-1:0] = st.trim_p;
            end
            OFF_TRIM_N:
            begin
               next_st.rdata[CODE_W-1:0] = st.trim_n;
            end
            OFF_RESULT:
            begin
               next_st.rdata[CODE_W-1:0] = st.result;
            end
            default:
            begin
               next_st.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         st             <= '0;
         st.fsm         <= S_OFF;
         st.ctl.ch      <= CH_RST;
         st.trim_p      <= TRIM_RST;
         st.trim_n      <= TRIM_RST;
         st.result      <= RESULT_RST;
         st.ana.mux_sel <= CH_RST;
         st.ana.differential <= 1'b1;
         st.ana.trim_pos <= TRIM_RST;
         st.ana.trim_neg <= TRIM_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   AST_START_LAUNCH: assert property (
      (st.fsm == S_TRACK) && st.ctl.start && st.ctl.reg_en &&
      st.ctl.conv_en && !(wr_en && addr == OFF_CTRL)
      |=> (st.fsm == S_CONV) && st.ana.hold && !st.ana.track)
      else $error("Start did not launch a conversion");

   AST_START_CLEAR: assert property (
      (st.fsm == S_CONV) && (st.conv_cnt == CONV_LAST) && !st.ctl.chop &&
      st.ctl.reg_en && st.ctl.conv_en && !(wr_en && addr == OFF_CTRL)
      |=> !st.ctl.start && (st.fsm == S_TRACK))
      else $error("Start not cleared after conversion");

   AST_CONV_LEN: assert property (
      (st.fsm == S_CONV) && (st.conv_cnt != CONV_LAST) && st.ctl.reg_en &&
      st.ctl.conv_en && !(wr_en && addr == OFF_CTRL)
      |=> (st.fsm == S_CONV) && (st.conv_cnt == $past(st.conv_cnt) + 4'h1))
      else $error("Conversion phase ended early");

   AST_TRACKING: assert property (
      (st.fsm == S_TRACK) |-> st.ana.track && !st.ana.hold &&
      st.ctl.conv_en)
      else $error("Enabled converter not tracking");

   AST_REG_OFF: assert property (
      !st.ctl.reg_en |-> (st.fsm == S_OFF) && !st.ana.regulator_on &&
      !st.ana.track)
      else $error("Converter alive with regulator off");

   AST_DYN_LOAD: assert property (
      st.ana.load10 |-> st.ana.track && st.ctl2.dload)
      else $error("Dynamic load outside sampling");

   AST_CONST_LOAD: assert property (
      st.ana.load20 == (st.ctl2.cload && st.ctl.reg_en))
      else $error("Constant load mismatch");

   AST_RESULT_HOLD: assert property (
      (st.fsm != S_CONV) |=> $stable(st.result))
      else $error("Result changed without conversion");

   AST_PIN_GATE: assert property (
      st.ana.pin_connect[0] |-> $past(analog_sel[0]) && !st.ctl.ch[2])
      else $error("Pin connected without analogue function");

   AST_ATTEN: assert property (
      st.ana.atten == (st.ctl2.attn || st.ctl.ch == CH_BATTERY))
      else $error("Attenuator state wrong");

   AST_MUTE: assert property (
      st.ana.mute == st.ctl.mute)
      else $error("Mute not applied to input");

   AST_INVERT: assert property (
      (st.fsm == S_TRACK) |-> (st.ana.invert == st.ctl.inv))
      else $error("Input sign not following invert");

endmodule

// [verification/gac_tb.sv]
// Self-checking bench of the converter control sequencer
`timescale 1ns/1ps
module testbench;
   import gac_pkg::*;
   typedef struct packed
   {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } gac_row_s;
   localparam logic [31:0] B_EN   = 32'h1 << CTL_EN_POS;
   localparam logic [31:0] B_ST   = 32'h1 << CTL_START_POS;
   localparam logic [31:0] B_CHOP = 32'h1 << CTL_CHOP_POS;
   localparam logic [31:0] B_SE   = 32'h1 << CTL_SE_POS;
   localparam logic [31:0] B_MUTE = 32'h1 << CTL_MUTE_POS;
   localparam logic [31:0] B_INV  = 32'h1 << CTL_INV_POS;
   localparam logic [31:0] B_REG  = 32'h1 << CTL_REG_POS;
   localparam logic [31:0] B_ON   = B_REG | B_EN;
   logic              core_clk = 1'b0;
   logic              reset = 1'b1;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [DATA_W-1:0] wr_data = 32'h0;
   logic              wr_en = 1'b0;
   logic              rd_en = 1'b0;
   logic [DATA_W-1:0] rd_data;
   logic [CODE_W-1:0] raw_code = 10'h000;
   logic [3:0]        analog_sel = 4'h0;
   gac_analog_s       ana;
   int                miscompares = 0;
   int                num_checks = 0;
   int                cyc = 0;
   int                hold_cnt = 0;
   int                load_bad = 0;
   int                hc;
   int                n;
   logic [31:0]       rv;
   logic [31:0]       cal_p;
   gac_row_s          rows [7] = '{
      '{OFF_CTRL2, 32'h0000_0007, 32'h0000_0007},
      '{OFF_CTRL2, 32'hFFFF_FFFF, 32'h0000_0007},
      '{OFF_TRIM_P, 32'h0000_03FF, 32'h0000_03FF},
      '{OFF_TRIM_N, 32'hFFFF_F155, 32'h0000_0155},
      '{OFF_RESULT, 32'h0000_0123, 32'h0000_0000},
      '{8'h14, 32'hFFFF_FFFF, 32'h0000_0000},
      '{OFF_CTRL, 32'h0000_01FC, 32'h0000_01FC}};

   gac_sequencer dut
   (
      .core_clk   (core_clk),
      .reset      (reset),
      .addr       (addr),
      .wr_data    (wr_data),
      .wr_en      (wr_en),
      .rd_en      (rd_en),
      .rd_data    (rd_data),
      .raw_code   (raw_code),
      .analog_sel (analog_sel),
      .ana        (ana)
   );

   always #2.5 core_clk = ~core_clk;

   // Hold length and loads seen during conversion
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (ana.hold === 1'b1)
      begin
         hold_cnt <= hold_cnt + 1;
      end
      if (ana.hold === 1'b1 && ana.load10 !== 1'b0)
      begin
         load_bad <= load_bad + 1;
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
   endtask

   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   // Starts a conversion, polls the start bit, returns the result
   task automatic run_conv(input logic [31:0] c, output logic [31:0] r);
      int base;
      base = hold_cnt;
      wr(OFF_CTRL, c | B_ST);
      n = 0;
      rd(OFF_CTRL, r);
      while (r[CTL_START_POS] !== 1'b0 && n < 60)
      begin
         rd(OFF_CTRL, r);
         n++;
      end
      if (n >= 60)
      begin
         miscompares++;
         final_report();
      end
      hc = hold_cnt - base;
      rd(OFF_RESULT, r);
   endtask

   initial
   begin
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      rd(OFF_CTRL, rv);
      chk("ctrl rst", 32'h0, rv);
      @(posedge core_clk);
      #1;
      chk("rd_data idle", 32'h0, rd_data);
      rd(OFF_TRIM_P, rv);
      chk("trim_p rst", 32'h200, rv);
      chk("diff rst", 1, ana.differential);
      for (int i = 0; i < 7; i++)
      begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rv);
         chk("row read", rows[i].e, rv);
      end
      chk("trim_pos", 32'h3FF, ana.trim_pos);
      chk("trim_neg", 32'h155, ana.trim_neg);
      wr(OFF_CTRL2, 32'h0);
      analog_sel <= 4'hF;
      for (int c = 0; c < 4; c++)
      begin
         wr(OFF_CTRL, B_SE | (32'(c) << CTL_CH_POS));
         settle();
         chk("mux_sel", 32'(c), ana.mux_sel);
         chk("pins se", 32'h1 << c, ana.pin_connect);
         chk("diff se", 0, ana.differential);
      end
      analog_sel <= 4'h7;
      settle();
      chk("pins off", 0, ana.pin_connect);
      analog_sel <= 4'hF;
      for (int c = 0; c < 2; c++)
      begin
         wr(OFF_CTRL, 32'(c) << CTL_CH_POS);
         settle();
         chk("pins diff", c ? 32'hC : 32'h3, ana.pin_connect);
         chk("diff", 1, ana.differential);
         chk("atten off", 0, ana.atten);
      end
      wr(OFF_CTRL, 32'h4 << CTL_CH_POS);
      settle();
      chk("atten batt", 1, ana.atten);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CTRL2, 32'h1 << CT2_ATTN_POS);
      settle();
      chk("atten bit", 1, ana.atten);
      chk("load20 off", 0, ana.load20);
      n = cyc;
      wr(OFF_CTRL, B_ON);
      wr(OFF_CTRL2, 32'h6);
      rd(OFF_CTRL, rv);
      chk("not ready", 0, rv[CTL_READY_POS]);
      chk("reg on", 1, ana.regulator_on);
      chk("track", 1, ana.track);
      chk("load20", 1, ana.load20);
      chk("load10", 1, ana.load10);
      for (int k = 0; k < 3000 && rv[CTL_READY_POS] !== 1'b1; k++)
      begin
         rd(OFF_CTRL, rv);
      end
      n = cyc - n;
      chk("ready", 1, rv[CTL_READY_POS]);
      chk("settle low", 1, n >= SETTLE_CYCLES - 2);
      chk("settle high", 1, n <= SETTLE_CYCLES + 8);
      raw_code <= 10'h155;
      run_conv(B_ON, rv);
      chk("result", 32'h155, rv);
      chk("hold len", 32'(CONV_CYCLES), 32'(hc));
      chk("track back", 1, ana.track);
      run_conv(B_ON | B_INV, rv);
      chk("inverted", 32'h2AA, rv);
      chk("invert out", 1, ana.invert);
      wr(OFF_CTRL, B_ON | B_MUTE);
      settle();
      chk("mute", 1, ana.mute);
      run_conv(B_ON | B_CHOP, rv);
      chk("chop", 32'h1FF, rv);
      chk("chop hold", 32'(2 * CONV_CYCLES), 32'(hc));
      chk("chop sign", 0, ana.invert);
      raw_code <= 10'h0AA;
      rd(OFF_RESULT, rv);
      chk("result kept", 32'h1FF, rv);
      wr(OFF_CTRL, B_REG | B_ST);
      rd(OFF_CTRL, rv);
      chk("pending", 1, rv[CTL_START_POS]);
      chk("no hold", 0, ana.hold);
      run_conv(B_ON, rv);
      chk("after pend", 32'h0AA, rv);
      raw_code <= 10'h3C3;
      wr(OFF_CTRL, B_ON | B_ST);
      wr(OFF_CTRL, B_REG);
      rd(OFF_CTRL, rv);
      chk("abort start", 0, rv[CTL_START_POS]);
      rd(OFF_RESULT, rv);
      chk("abort result", 32'h0AA, rv);
      chk("load10 in hold", 0, 32'(load_bad));
      // Offset calibration as software runs it, comparator offset +3
      raw_code <= 10'h203;
      wr(OFF_TRIM_P, 32'h200);
      wr(OFF_TRIM_N, 32'h200);
      run_conv(B_ON | B_MUTE, cal_p);
      chk("cal pos", 32'h203, cal_p);
      run_conv(B_ON | B_MUTE | B_INV, rv);
      chk("cal neg", 32'h1FC, rv);
      chk("cal sum", 32'h1FF, (cal_p + rv) >> 1);
      wr(OFF_TRIM_P, 32'h400 - cal_p);
      wr(OFF_TRIM_N, 32'h400 - rv);
      settle();
      chk("cal trim_p", 32'h1FD, ana.trim_pos);
      chk("cal trim_n", 32'h204, ana.trim_neg);
      chk("cal avg", 32'h200,
          (32'(ana.trim_pos) + 32'(ana.trim_neg)) >> 1);
      wr(OFF_CTRL, 32'h0);
      settle();
      chk("reg off", 0, ana.regulator_on);
      chk("load20 reg", 0, ana.load20);
      chk("track off", 0, ana.track);
      wr(OFF_CTRL, B_REG | B_ST);
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      chk("hold rst", 0, ana.hold);
      rd(OFF_CTRL, rv);
      chk("ctrl rst2", 32'h0, rv);
      final_report();
   end
endmodule
